// ===== hw/dac_clock_sysref_pll_control.sv
// clock tree, alignment reference receiver and converter pll control registers
`include "clk_ctrl_cfg.svh"

module dac_clock_sysref_pll_control
    import clk_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      srst,
    // register port
    input  wire logic      reg_write,
    input  wire logic      reg_read,
    input  wire logic [7:0] reg_addr,
    input  wire reg_byte_t reg_wdata,
    output logic           reg_rvalid,
    output reg_byte_t      reg_rdata,
    // clock tree controls
    output logic           pair_a_clock_off,
    output logic           pair_b_clock_off,
    output logic           all_converter_clocks_off,
    output logic           link_pll_ref_off,
    output logic           clock_receiver_off,
    output logic           pair_a_clock_run,
    output logic           pair_b_clock_run,
    // alignment reference receiver
    output logic           align_ref_buffer_off,
    output logic           hysteresis_enable,
    output hys_code_t      hysteresis_code,
    output logic           align_ref_edge_select,
    // converter pll
    output logic           pll_run,
    output logic           pll_cal_start,
    input  wire logic      pll_band_high_flag,
    input  wire logic      pll_band_low_flag,
    input  wire logic      pll_cal_done,
    input  wire logic      pll_locked
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg_byte_t clock_gating_config;
    reg_byte_t align_ref_receiver_ctrl;
    reg_byte_t align_ref_hysteresis_low;
    reg_byte_t converter_pll_control;

    pll_status_if ctl ();

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = reg_write && (addr == ofs);
    endfunction : hit

    always_ff @(posedge clk) begin
        if (srst) begin
            clock_gating_config <= `RST_CLOCK_GATING;
        end else if (hit(reg_addr, `OFS_CLOCK_GATING)) begin
            clock_gating_config <= reg_wdata & `MASK_CLOCK_GATING;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            align_ref_receiver_ctrl <= `RST_ALIGN_REF_CTRL;
        end else if (hit(reg_addr, `OFS_ALIGN_REF_CTRL)) begin
            align_ref_receiver_ctrl <= reg_wdata & `MASK_ALIGN_REF_CTRL;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            align_ref_hysteresis_low <= `RST_HYS_LO;
        end else if (hit(reg_addr, `OFS_ALIGN_REF_HYS_LO)) begin
            align_ref_hysteresis_low <= reg_wdata;
        end
    end

    // recal is edge-triggered: keep the stored level and compare old to new
    logic recal_edge;

    always_ff @(posedge clk) begin
        if (srst) begin
            converter_pll_control <= `RST_PLL_CONTROL;
            recal_edge            <= 1'b0;
        end else begin
            recal_edge <= 1'b0;
            if (hit(reg_addr, `OFS_PLL_CONTROL)) begin
                converter_pll_control <= reg_wdata & `MASK_PLL_CONTROL;
                recal_edge <= reg_wdata[`BIT_RECAL]
                            & ~converter_pll_control[`BIT_RECAL];
            end
        end
    end

    // ----------------------------------------
    // pll sequencing
    // ----------------------------------------
    assign ctl.synth_enable = converter_pll_control[`BIT_SYNTH_EN];
    assign ctl.recal_pulse  = recal_edge;

    pll_sequencer u_seq (
        .clk                (clk),
        .srst               (srst),
        .pll_band_high_flag (pll_band_high_flag),
        .pll_band_low_flag  (pll_band_low_flag),
        .pll_cal_done       (pll_cal_done),
        .pll_locked         (pll_locked),
        .ctl                (ctl.seq)
    );

    // start is a one-cycle pulse, registered to keep the output glitch free
    always_ff @(posedge clk) begin
        if (srst) begin
            pll_run       <= 1'b0;
            pll_cal_start <= 1'b0;
        end else begin
            pll_run       <= ctl.pll_run;
            pll_cal_start <= ctl.cal_start;
        end
    end

    // ----------------------------------------
    // clock tree and receiver controls
    // ----------------------------------------
    always_comb begin
        pair_a_clock_off         = clock_gating_config[`BIT_PAIR_A_OFF];
        pair_b_clock_off         = clock_gating_config[`BIT_PAIR_B_OFF];
        all_converter_clocks_off = clock_gating_config[`BIT_ALL_OFF];
        link_pll_ref_off         = clock_gating_config[`BIT_LINK_REF_OFF];
        clock_receiver_off       = clock_gating_config[`BIT_RECEIVER_OFF];
        // any upstream gate stops a pair, since the global and receiver gates feed both
        pair_a_clock_run = ~(pair_a_clock_off | all_converter_clocks_off
                           | clock_receiver_off);
        pair_b_clock_run = ~(pair_b_clock_off | all_converter_clocks_off
                           | clock_receiver_off);
        align_ref_buffer_off  = align_ref_receiver_ctrl[`BIT_ALIGN_BUF_OFF];
        hysteresis_enable     = align_ref_receiver_ctrl[`BIT_HYS_ENABLE];
        align_ref_edge_select = align_ref_receiver_ctrl[`BIT_EDGE_SELECT];
        // code passes only when enabled, so with hysteresis_enable low the code is zero, whether or not the buffer is off
        hysteresis_code = hysteresis_enable
                        ? {align_ref_receiver_ctrl[1:0], align_ref_hysteresis_low}
                        : 10'h000;
    end

    // ----------------------------------------
    // readback
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rvalid <= 1'b0;
            reg_rdata  <= 8'h00;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                unique case (reg_addr)
                    `OFS_CLOCK_GATING:     reg_rdata <= clock_gating_config;
                    `OFS_ALIGN_REF_CTRL:   reg_rdata <= align_ref_receiver_ctrl;
                    `OFS_ALIGN_REF_HYS_LO: reg_rdata <= align_ref_hysteresis_low;
                    `OFS_PLL_CONTROL:      reg_rdata <= converter_pll_control;
                    `OFS_PLL_STATUS:       reg_rdata <= ctl.status_byte;
                    default:               reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule : dac_clock_sysref_pll_control

// ===== hw/pll_sequencer.sv
// synchronises pll status pins and sequences enable and calibration starts
`include "clk_ctrl_cfg.svh"

module pll_sequencer
    import clk_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // pll status pins, asynchronous
    input  wire logic pll_band_high_flag,
    input  wire logic pll_band_low_flag,
    input  wire logic pll_cal_done,
    input  wire logic pll_locked,
    // register side
    pll_status_if.seq ctl
);

    // ----------------------------------------
    // status synchronisers
    // ----------------------------------------
    logic [3:0] meta;
    logic [3:0] sync;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= 4'h0;
            sync <= 4'h0;
        end else begin
            meta <= {pll_band_high_flag, pll_band_low_flag, pll_cal_done, pll_locked};
            sync <= meta;
        end
    end

    // ----------------------------------------
    // enable and calibration start
    // ----------------------------------------
    logic enable_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            enable_q <= 1'b0;
        end else begin
            enable_q <= ctl.synth_enable;
        end
    end

    // enable rising or a recal edge starts calibration; recal ignored while pll off
    assign ctl.pll_run   = ctl.synth_enable;
    assign ctl.cal_start = (ctl.synth_enable & ~enable_q)
                         | (ctl.recal_pulse & ctl.synth_enable);

    always_comb begin
        ctl.status_byte = 8'h00;
        ctl.status_byte[`BIT_BAND_HIGH] = sync[3];
        ctl.status_byte[`BIT_BAND_LOW]  = sync[2];
        ctl.status_byte[`BIT_CAL_DONE]  = sync[1];
        ctl.status_byte[`BIT_LOCKED]    = sync[0];
    end

endmodule : pll_sequencer

// ===== include/clk_ctrl_cfg.svh
// register offsets, field positions, reset values and timing counts for the clock control block
`ifndef CLK_CTRL_CFG_SVH
`define CLK_CTRL_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CLOCK_GATING     8'h80
`define OFS_ALIGN_REF_CTRL   8'h81
`define OFS_ALIGN_REF_HYS_LO 8'h82
`define OFS_PLL_CONTROL      8'h83
`define OFS_PLL_STATUS       8'h84

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_PAIR_A_OFF       7
`define BIT_PAIR_B_OFF       6
`define BIT_ALL_OFF          5
`define BIT_LINK_REF_OFF     4
`define BIT_RECEIVER_OFF     3
`define BIT_ALIGN_BUF_OFF    4
`define BIT_HYS_ENABLE       3
`define BIT_EDGE_SELECT      2
`define BIT_RECAL            7
`define BIT_SYNTH_EN         4
`define BIT_BAND_HIGH        7
`define BIT_BAND_LOW         6
`define BIT_CAL_DONE         5
`define BIT_LOCKED           1

// ----------------------------------------
// reset values, writable masks and the read-only status bit mask
// ----------------------------------------
`define RST_CLOCK_GATING     8'hF8
`define RST_ALIGN_REF_CTRL   8'h10
`define RST_HYS_LO           8'h00
`define RST_PLL_CONTROL      8'h00
`define MASK_CLOCK_GATING    8'hF8
`define MASK_ALIGN_REF_CTRL  8'h1F
`define MASK_PLL_CONTROL     8'h90
`define MASK_PLL_STATUS      8'hE2

// ----------------------------------------
// timing
// ----------------------------------------
`define RECAL_PULSE_CYCLES   1

`endif

// ===== include/clk_ctrl_pkg.sv
// types shared by the clock control block
package clk_ctrl_pkg;

    typedef logic [7:0] reg_byte_t;
    typedef logic [9:0] hys_code_t;

    typedef struct packed {
        logic pair_a_clock_off;
        logic pair_b_clock_off;
        logic all_converter_clocks_off;
        logic link_pll_ref_off;
        logic clock_receiver_off;
    } clock_gates_s;

endpackage : clk_ctrl_pkg

// ===== include/pll_status_if.sv
// carrier between the register file and the pll sequencer
interface pll_status_if;
    logic synth_enable;
    logic recal_pulse;
    logic pll_run;
    logic cal_start;
    logic [7:0] status_byte;

    modport regs (output synth_enable, output recal_pulse, input pll_run, input cal_start,
                  input status_byte);
    modport seq  (input synth_enable, input recal_pulse, output pll_run, output cal_start,
                  output status_byte);
endinterface : pll_status_if

// ===== sim/dac_clock_sysref_pll_control_assertions.sv
// port-level checks for the clock control block
module dac_clock_sysref_pll_control_assertions
    import clk_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // register port
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_addr,
    input  wire reg_byte_t  reg_wdata,
    input  wire logic       reg_rvalid,
    input  wire reg_byte_t  reg_rdata,
    // clock tree
    input  wire logic       pair_a_clock_off,
    input  wire logic       pair_b_clock_off,
    input  wire logic       all_converter_clocks_off,
    input  wire logic       link_pll_ref_off,
    input  wire logic       clock_receiver_off,
    input  wire logic       pair_a_clock_run,
    input  wire logic       pair_b_clock_run,
    // alignment reference and pll
    input  wire logic       align_ref_buffer_off,
    input  wire logic       hysteresis_enable,
    input  wire hys_code_t  hysteresis_code,
    input  wire logic       align_ref_edge_select,
    input  wire logic       pll_run,
    input  wire logic       pll_cal_start
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_pair_a_run;
        pair_a_clock_run == !(pair_a_clock_off || all_converter_clocks_off || clock_receiver_off);
    endproperty
    a_pair_a_run: assert property (p_pair_a_run)
        else $error("pair a run wrong");
    property p_pair_b_run;
        pair_b_clock_run == !(pair_b_clock_off || all_converter_clocks_off || clock_receiver_off);
    endproperty
    a_pair_b_run: assert property (p_pair_b_run)
        else $error("pair b run wrong");
    property p_gate_write;
        reg_write && reg_addr == 8'h80 |=> {pair_a_clock_off, pair_b_clock_off,
            all_converter_clocks_off, link_pll_ref_off, clock_receiver_off} == $past(reg_wdata[7:3]);
    endproperty
    a_gate_write: assert property (p_gate_write)
        else $error("gates wrong");
    property p_ref_write;
        reg_write && reg_addr == 8'h81 |=> {align_ref_buffer_off, hysteresis_enable,
            align_ref_edge_select} == $past(reg_wdata[4:2]);
    endproperty
    a_ref_write: assert property (p_ref_write)
        else $error("ref ctrl wrong");
    property p_hys_zero;
        !hysteresis_enable |-> hysteresis_code == 10'h000;
    endproperty
    a_hys_zero: assert property (p_hys_zero)
        else $error("hysteresis leaks");
    property p_hys_code;
        reg_write && reg_addr == 8'h82 && hysteresis_enable
            |=> !hysteresis_enable || hysteresis_code[7:0] == $past(reg_wdata);
    endproperty
    a_hys_code: assert property (p_hys_code)
        else $error("hysteresis low wrong");
    property p_enable_start;
        $rose(pll_run) |-> pll_cal_start;
    endproperty
    a_enable_start: assert property (p_enable_start)
        else $error("no cal start");
    property p_enable_delay;
        reg_write && reg_addr == 8'h83 |=> ##1 pll_run == $past(reg_wdata[4], 2);
    endproperty
    a_enable_delay: assert property (p_enable_delay)
        else $error("pll run late");
    property p_status_read;
        reg_read && reg_addr == 8'h84 |=> reg_rvalid && reg_rdata[4:2] == 3'h0 && !reg_rdata[0];
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status reserved set");
    c_cal: cover property (pll_cal_start);
    c_read: cover property (reg_read ##1 reg_rvalid);
    c_hys: cover property (hysteresis_enable && hysteresis_code != 10'h000);
endmodule : dac_clock_sysref_pll_control_assertions

bind dac_clock_sysref_pll_control dac_clock_sysref_pll_control_assertions u_assertions (
    .clk, .srst, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rvalid, .reg_rdata,
    .pair_a_clock_off, .pair_b_clock_off, .all_converter_clocks_off, .link_pll_ref_off,
    .clock_receiver_off, .pair_a_clock_run, .pair_b_clock_run, .align_ref_buffer_off,
    .hysteresis_enable, .hysteresis_code, .align_ref_edge_select, .pll_run, .pll_cal_start);

// ===== sim/testbench.sv
// self-checking bench for the clock control block
module testbench
    import clk_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, srst = 1, reg_write = 0, reg_read = 0, reg_rvalid, pll_run, pll_cal_start;
    logic [7:0] reg_addr = 8'h00;
    reg_byte_t  reg_wdata = 8'h00, reg_rdata;
    logic [3:0] pins = 4'h0;
    logic pair_a_clock_off, pair_b_clock_off, all_converter_clocks_off, link_pll_ref_off;
    logic clock_receiver_off, pair_a_clock_run, pair_b_clock_run, align_ref_buffer_off;
    logic hysteresis_enable, align_ref_edge_select;
    hys_code_t  hysteresis_code;
    int fail_count = 0, comparisons = 0, cycles = 0, cal_count = 0, base;
    reg_byte_t  gates [6] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h08, 8'h10};
    reg_byte_t  recal [9] = '{8'h90, 8'h90, 8'h10, 8'h90, 8'h00, 8'h80, 8'h00, 8'h90, 8'h80};
    int         recal_exp [9] = '{1, 0, 0, 1, 0, 0, 0, 1, 0};
    reg_byte_t  pin_bits [4] = '{8'h80, 8'h40, 8'h20, 8'h02};

    dac_clock_sysref_pll_control u_dac_clock_sysref_pll_control (
        .clk, .srst, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rvalid, .reg_rdata,
        .pair_a_clock_off, .pair_b_clock_off, .all_converter_clocks_off, .link_pll_ref_off,
        .clock_receiver_off, .pair_a_clock_run, .pair_b_clock_run, .align_ref_buffer_off,
        .hysteresis_enable, .hysteresis_code, .align_ref_edge_select, .pll_run, .pll_cal_start,
        .pll_band_high_flag(pins[3]), .pll_band_low_flag(pins[2]), .pll_cal_done(pins[1]),
        .pll_locked(pins[0]));

    // ----------------------------------------
    // clock, timeout, pulse counter
    // ----------------------------------------
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (pll_cal_start === 1'b1) cal_count++;
        // whole run is under 150 cycles, so this only trips on a hang
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic wr(input logic [7:0] a, input reg_byte_t d);
        idle(1);
        reg_write = 1;
        reg_addr  = a;
        reg_wdata = d;
        idle(1);
        reg_write = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input reg_byte_t e);
        idle(1);
        reg_read = 1;
        reg_addr = a;
        idle(1);
        reg_read = 0;
        chk(reg_rvalid, 1'b1);
        chk(reg_rdata, e);
    endtask : rd
    task automatic finish_test();
        if (fail_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        idle(16);
        srst = 0;
        rd(8'h80, 8'hF8);
        rd(8'h81, 8'h10);
        rd(8'h82, 8'h00);
        rd(8'h83, 8'h00);
        rd(8'h84, 8'h00);
        chk({pair_a_clock_run, pair_b_clock_run, pll_run}, 3'b000);
        wr(8'h80, 8'hFF);
        rd(8'h80, 8'hF8);
        foreach (gates[i]) begin
            wr(8'h80, gates[i]);
            chk({pair_a_clock_off, pair_b_clock_off}, gates[i][7:6]);
            chk(all_converter_clocks_off, gates[i][5]);
            chk({link_pll_ref_off, clock_receiver_off}, gates[i][4:3]);
            chk({pair_a_clock_run, pair_b_clock_run},
                {~(gates[i][7] | gates[i][5] | gates[i][3]),
                 ~(gates[i][6] | gates[i][5] | gates[i][3])});
        end
        wr(8'h81, 8'hFF);
        rd(8'h81, 8'h1F);
        wr(8'h82, 8'hA5);
        chk(hysteresis_code, 10'h3A5);
        chk({align_ref_buffer_off, hysteresis_enable, align_ref_edge_select}, 3'b111);
        wr(8'h81, 8'h03);
        chk(hysteresis_code, 10'h000);
        chk({align_ref_buffer_off, align_ref_edge_select}, 2'b00);
        wr(8'h81, 8'h0C);
        chk(hysteresis_code, 10'h0A5);
        chk(align_ref_edge_select, 1'b1);
        wr(8'h84, 8'hFF);
        rd(8'h84, 8'h00);
        rd(8'h85, 8'h00);
        // recal only counts while enabled, and only on a fresh zero-to-one write
        base = cal_count;
        wr(8'h83, 8'h10);
        idle(3);
        chk(pll_run, 1'b1);
        chk(10'(cal_count - base), 10'h001);
        // enable and recal rising in one write must still give a single start
        foreach (recal[i]) begin
            base = cal_count;
            wr(8'h83, recal[i]);
            idle(3);
            chk(10'(cal_count - base), 10'(recal_exp[i]));
        end
        chk(pll_run, 1'b0);
        rd(8'h83, 8'h80);
        foreach (pin_bits[i]) begin
            pins = 4'b1000 >> i;
            idle(2);
            rd(8'h84, pin_bits[i]);
        end
        pins = 4'h0;
        idle(2);
        rd(8'h84, 8'h00);
        srst = 1;
        idle(2);
        srst = 0;
        rd(8'h80, 8'hF8);
        rd(8'h81, 8'h10);
        rd(8'h83, 8'h00);
        finish_test();
    end
endmodule : testbench
